// ===== rtl/dhs_params.svh
/*
   Constants of the drive health status block: register offsets, command
   codes, structure offsets and fixed values, reset values.
   Assumes inclusion by bare name from the package and the top module.
*/
`ifndef DHS_PARAMS_SVH
`define DHS_PARAMS_SVH

// Register byte offsets
`define DHS_A_CMD      8'h00
`define DHS_A_STAT     8'h04
`define DHS_A_ATTR     8'h08
`define DHS_A_COLL     8'h0C
`define DHS_A_DATA     8'h10
// Subcommand codes and sector count keys
`define DHS_SUB_RDVAL  8'hD0
`define DHS_SUB_RDTHR  8'hD1
`define DHS_SUB_HEALTH 8'hDA
`define DHS_SUB_AUTO   8'hDB
`define DHS_AUTO_OFF   8'h00
`define DHS_AUTO_ON    8'hF8
// Health signatures
`define DHS_OK_LO      8'h4F
`define DHS_OK_HI      8'hC2
`define DHS_BAD_LO     8'hF4
`define DHS_BAD_HI     8'h2C
// Structure layout
`define DHS_REV_LO     8'h10
`define DHS_REV_HI     8'h00
`define DHS_N_ATTR     5'd30
`define DHS_ENT_BYTES  9'd12
`define DHS_O_ENT      9'h002
`define DHS_O_COLL     9'h16A
`define DHS_O_ST       9'h16B
`define DHS_O_TTIME    9'h16C
`define DHS_O_OFFCAP   9'h16F
`define DHS_O_CAP      9'h170
`define DHS_O_ELOG     9'h172
`define DHS_O_SHORT    9'h174
`define DHS_O_EXT      9'h175
`define DHS_O_CSUM     9'h1FF
`define DHS_OFFCAP     8'h1B
`define DHS_CAP        8'h03
`define DHS_ELOG       8'h01
`define DHS_VAL_MIN    8'h01
`define DHS_VAL_MAX    8'hFD
`define DHS_ST_MAXPCT  4'h9
`define DHS_ST_RUN     4'hF
`define DHS_PREFAIL    30'h0000_0177
// Reset values
`define DHS_RST_COLL   7'h00
`define DHS_RST_ST     8'h00
`define DHS_RST_VAL    8'h64
// AXI responses
`define DHS_OKAY       2'b00
`define DHS_SLVERR     2'b10
`define DHS_DECERR     2'b11
`endif

// ===== rtl/dhs_pkg.sv
/*
   Types of the drive health status block.
   Assumes dhs_params.svh on the include path.
*/
`include "dhs_params.svh"
package dhs_pkg;
   typedef enum logic [1:0] {
      DHS_IDLE = 2'b00,
      DHS_SAVE = 2'b01,
      DHS_CMP  = 2'b10,
      DHS_DONE = 2'b11
   } dhs_state_t;

   typedef struct packed {
      logic [7:0]  id;
      logic [15:0] flags;
      logic [7:0]  thr;
   } dhs_attr_t;

   typedef struct packed {
      logic [7:0] cnt;
      logic [7:0] sub;
   } dhs_cmd_t;
endpackage

// ===== rtl/dhs_top.sv
/*
   Drive health status block: health report, automatic collection control,
   attribute value and threshold sectors streamed to the host over an
   AXI4-Lite register port.
   Assumes a single 20 MHz clock, firmware feeding attribute values, and a
   save request pin from the power and recovery logic.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dhs_params.svh"
module dhs_top
   import dhs_pkg::*;
#(
   parameter logic [7:0]  THR_PREFAIL  = 8'h10,
   parameter logic [7:0]  THR_ADVISORY = 8'h00,
   parameter logic [15:0] COLL_TIME_S  = 16'h0000,
   parameter logic [7:0]  SHORT_MIN    = 8'h01,
   parameter logic [7:0]  EXT_MIN      = 8'h01
)(
   // Clock and reset
   input  wire logic        SYS_CLK,
   input  wire logic        RST_B,
   // AXI4-Lite write address and data
   input  wire logic [7:0]  S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   // AXI4-Lite write response
   output logic [1:0]       S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   // AXI4-Lite read
   input  wire logic [7:0]  S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   // Drive side
   input  wire logic        SAVE_REQ,
   output logic             COLLECT_EN,
   output logic             COLLECT_GO
);

   // Pre-failure map; a named value, since a bare literal cannot be bit-selected
   localparam logic [29:0] PREFAIL_MAP = `DHS_PREFAIL;

   // Fixed attribute table; thresholds are set here at build time only
   function automatic dhs_attr_t entry(input logic [4:0] k);
      dhs_attr_t e;
      e = '0;
      case (k)
         5'd0:    e.id = 8'h01;
         5'd1:    e.id = 8'h02;
         5'd2:    e.id = 8'h03;
         5'd3:    e.id = 8'h04;
         5'd4:    e.id = 8'h05;
         5'd5:    e.id = 8'h07;
         5'd6:    e.id = 8'h08;
         5'd7:    e.id = 8'h09;
         5'd8:    e.id = 8'h0A;
         5'd9:    e.id = 8'h0C;
         5'd10:   e.id = 8'hC0;
         5'd11:   e.id = 8'hC1;
         5'd12:   e.id = 8'hC2;
         5'd13:   e.id = 8'hC4;
         5'd14:   e.id = 8'hC5;
         5'd15:   e.id = 8'hC6;
         5'd16:   e.id = 8'hC7;
         default: e.id = 8'h00;
      endcase
      if (e.id != 8'h00) begin
         e.flags = {14'h0000, 1'b1, PREFAIL_MAP[k]};
         e.thr   = PREFAIL_MAP[k] ? THR_PREFAIL : THR_ADVISORY;
      end
      return e;
   endfunction

   // Normalized value held inside the documented range
   function automatic logic [7:0] clamp(input logic [7:0] v);
      if (v < `DHS_VAL_MIN) return `DHS_VAL_MIN;
      if (v > `DHS_VAL_MAX) return `DHS_VAL_MAX;
      return v;
   endfunction

   // Register index from a byte address
   function automatic logic [5:0] widx(input logic [7:0] a);
      return a[7:2];
   endfunction

   logic             aw_got_reg;
   logic             w_got_reg;
   logic [7:0]       awaddr_reg;
   logic [31:0]      wdata_reg;
   logic [3:0]       wstrb_reg;
   logic             bvalid_reg;
   logic [1:0]       bresp_reg;
   logic             rvalid_reg;
   logic [1:0]       rresp_reg;
   logic [31:0]      rdata_reg;
   logic             aw_hs;
   logic             w_hs;
   logic             ar_hs;
   logic             wr_do;
   logic [7:0]       wa;
   logic [31:0]      wd;
   logic [3:0]       ws;
   dhs_cmd_t         cmd_reg;
   logic             cmd_fire;
   logic             attr_fire;
   logic             coll_fire;
   logic             data_rd;
   dhs_state_t       state_reg;
   logic [4:0]       idx_reg;
   logic             exceed_reg;
   logic             save_only_reg;
   logic             save_pend_reg;
   logic [29:0]      upd_reg;
   logic [7:0]       cur_reg [0:29];
   logic [7:0]       saved_reg [0:29];
   dhs_attr_t        e_fsm;
   logic [7:0]       cyl_lo_reg;
   logic [7:0]       cyl_hi_reg;
   logic             auto_en_reg;
   logic             go_reg;
   logic             err_reg;
   logic [6:0]       coll_code_reg;
   logic [7:0]       st_reg;
   logic             s1_reg;
   logic             s2_reg;
   logic             s3_reg;
   logic             save_lvl_reg;
   logic             save_edge;
   logic             strm_act_reg;
   logic             strm_thr_reg;
   logic [8:0]       strm_ptr_reg;
   logic [7:0]       strm_sum_reg;
   logic [8:0]       rel;
   logic [4:0]       ent_i;
   logic [3:0]       ent_b;
   dhs_attr_t        ent;
   logic [7:0]       sbyte;

   // Handshake outputs; one write and one read in flight at most
   assign S_AXI_AWREADY = ~aw_got_reg & ~bvalid_reg;
   assign S_AXI_WREADY  = ~w_got_reg & ~bvalid_reg;
   assign S_AXI_ARREADY = ~rvalid_reg;
   assign S_AXI_BVALID  = bvalid_reg;
   assign S_AXI_BRESP   = bresp_reg;
   assign S_AXI_RVALID  = rvalid_reg;
   assign S_AXI_RRESP   = rresp_reg;
   assign S_AXI_RDATA   = rdata_reg;
   assign COLLECT_EN    = auto_en_reg;
   assign COLLECT_GO    = go_reg;

   // Write channel merge: address and data may arrive in either order
   assign aw_hs = S_AXI_AWVALID & S_AXI_AWREADY;
   assign w_hs  = S_AXI_WVALID & S_AXI_WREADY;
   assign ar_hs = S_AXI_ARVALID & S_AXI_ARREADY;
   assign wr_do = (aw_hs | aw_got_reg) & (w_hs | w_got_reg);
   assign wa    = aw_got_reg ? awaddr_reg : S_AXI_AWADDR;
   assign wd    = w_got_reg ? wdata_reg : S_AXI_WDATA;
   assign ws    = w_got_reg ? wstrb_reg : S_AXI_WSTRB;
   assign cmd_fire  = wr_do & (widx(wa) == widx(`DHS_A_CMD)) & ws[0];
   assign attr_fire = wr_do & (widx(wa) == widx(`DHS_A_ATTR)) & (&ws[1:0]);
   assign coll_fire = wr_do & (widx(wa) == widx(`DHS_A_COLL)) & (&ws[1:0]);
   assign data_rd   = ar_hs & (widx(S_AXI_ARADDR) == widx(`DHS_A_DATA)) & strm_act_reg;

   // Write address, data and response
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         aw_got_reg <= 1'b0;
         w_got_reg  <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg  <= 32'h0000_0000;
         wstrb_reg  <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg  <= `DHS_OKAY;
      end else begin
         if (wr_do) begin
            aw_got_reg <= 1'b0;
            w_got_reg  <= 1'b0;
            bvalid_reg <= 1'b1;
            case (widx(wa))
               widx(`DHS_A_CMD), widx(`DHS_A_ATTR), widx(`DHS_A_COLL): begin
                  bresp_reg <= `DHS_OKAY;
               end
               widx(`DHS_A_STAT), widx(`DHS_A_DATA): begin
                  bresp_reg <= `DHS_SLVERR; // Read-only word
               end
               default: begin
                  bresp_reg <= `DHS_DECERR;
               end
            endcase
         end else begin
            if (aw_hs) begin
               aw_got_reg <= 1'b1;
               awaddr_reg <= S_AXI_AWADDR;
            end
            if (w_hs) begin
               w_got_reg <= 1'b1;
               wdata_reg <= S_AXI_WDATA;
               wstrb_reg <= S_AXI_WSTRB;
            end
            if (bvalid_reg && S_AXI_BREADY) begin
               bvalid_reg <= 1'b0;
            end
         end
      end
   end

   // Read data; reading the data word pops one sector byte
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         rvalid_reg <= 1'b0;
         rresp_reg  <= `DHS_OKAY;
         rdata_reg  <= 32'h0000_0000;
      end else if (ar_hs) begin
         rvalid_reg <= 1'b1;
         rresp_reg  <= `DHS_OKAY;
         rdata_reg  <= 32'h0000_0000;
         case (widx(S_AXI_ARADDR))
            widx(`DHS_A_CMD): begin
               rdata_reg <= {16'h0000, cmd_reg};
            end
            widx(`DHS_A_STAT): begin
               rdata_reg <= {3'b000, strm_ptr_reg, strm_act_reg, err_reg,
                             (state_reg != DHS_IDLE), auto_en_reg, cyl_hi_reg, cyl_lo_reg};
            end
            widx(`DHS_A_ATTR): begin
               rdata_reg <= {2'b00, upd_reg};
            end
            widx(`DHS_A_COLL): begin
               rdata_reg <= {16'h0000, st_reg, 1'b0, coll_code_reg};
            end
            widx(`DHS_A_DATA): begin
               if (strm_act_reg) begin
                  rdata_reg <= {23'h000000, (strm_ptr_reg == `DHS_O_CSUM), sbyte};
               end else begin
                  rresp_reg <= `DHS_SLVERR; // No sector pending
               end
            end
            default: begin
               rresp_reg <= `DHS_DECERR;
            end
         endcase
      end else if (rvalid_reg && S_AXI_RREADY) begin
         rvalid_reg <= 1'b0;
      end
   end

   // Last command word, kept for readback
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         cmd_reg <= '0;
      end else if (cmd_fire) begin
         cmd_reg <= {(ws[1] ? wd[15:8] : 8'h00), wd[7:0]};
      end
   end

   // Save request pin: three stages, a change counts when stages two and three agree
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         s1_reg       <= 1'b0;
         s2_reg       <= 1'b0;
         s3_reg       <= 1'b0;
         save_lvl_reg <= 1'b0;
      end else begin
         s1_reg <= SAVE_REQ;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            save_lvl_reg <= s3_reg;
         end
      end
   end
   assign save_edge = (s2_reg == s3_reg) & s3_reg & ~save_lvl_reg;

   // Automatic collection control and error flag
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         auto_en_reg <= 1'b0;
         go_reg      <= 1'b0;
         err_reg     <= 1'b0;
      end else begin
         go_reg <= 1'b0;
         if (cmd_fire) begin
            err_reg <= 1'b0;
            if (wd[7:0] == `DHS_SUB_AUTO) begin
               if (ws[1] && wd[15:8] != `DHS_AUTO_OFF) begin
                  if (wd[15:8] == `DHS_AUTO_ON) begin
                     auto_en_reg <= 1'b1;
                     go_reg      <= 1'b1;
                  end else begin
                     err_reg <= 1'b1;
                  end
               end else begin
                  auto_en_reg <= 1'b0;
               end
            end
         end
      end
   end

   // Collection and self-test status from firmware; illegal codes are dropped
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         coll_code_reg <= `DHS_RST_COLL;
         st_reg        <= `DHS_RST_ST;
      end else if (coll_fire) begin
         case (wd[6:0])
            7'h00, 7'h02, 7'h04, 7'h05, 7'h06: coll_code_reg <= wd[6:0];
            default: coll_code_reg <= coll_code_reg;
         endcase
         if (wd[11:8] <= `DHS_ST_MAXPCT &&
             (wd[15] == 1'b0 || wd[15:12] == `DHS_ST_RUN)) begin
            st_reg <= wd[15:8];
         end
      end
   end

   // Health pass: save updated pre-failure values, then compare against thresholds
   assign e_fsm = entry(idx_reg);
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         state_reg     <= DHS_IDLE;
         idx_reg       <= 5'd0;
         exceed_reg    <= 1'b0;
         save_only_reg <= 1'b0;
         save_pend_reg <= 1'b0;
         cyl_lo_reg    <= 8'h00;
         cyl_hi_reg    <= 8'h00;
      end else begin
         if (save_edge) begin
            save_pend_reg <= 1'b1;
         end
         case (state_reg)
            DHS_IDLE: begin
               idx_reg    <= 5'd0;
               exceed_reg <= 1'b0;
               if (cmd_fire && wd[7:0] == `DHS_SUB_HEALTH) begin
                  save_only_reg <= 1'b0;
                  state_reg     <= DHS_SAVE;
               end else if (save_pend_reg) begin
                  save_only_reg <= 1'b1;
                  save_pend_reg <= save_edge;
                  state_reg     <= DHS_SAVE;
               end
            end
            DHS_SAVE: begin
               idx_reg <= idx_reg + 5'd1;
               if (idx_reg == `DHS_N_ATTR - 5'd1) begin
                  idx_reg   <= 5'd0;
                  state_reg <= save_only_reg ? DHS_IDLE : DHS_CMP;
               end
            end
            DHS_CMP: begin
               if (e_fsm.id != 8'h00 && saved_reg[idx_reg] <= e_fsm.thr) begin
                  exceed_reg <= 1'b1;
               end
               idx_reg <= idx_reg + 5'd1;
               if (idx_reg == `DHS_N_ATTR - 5'd1) begin
                  state_reg <= DHS_DONE;
               end
            end
            DHS_DONE: begin
               cyl_lo_reg <= exceed_reg ? `DHS_BAD_LO : `DHS_OK_LO;
               cyl_hi_reg <= exceed_reg ? `DHS_BAD_HI : `DHS_OK_HI;
               state_reg  <= DHS_IDLE;
            end
            default: begin
               state_reg <= DHS_IDLE;
            end
         endcase
      end
   end

   // Attribute store: a new value in the save cycle keeps its update mark
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         upd_reg <= 30'h0000_0000;
         for (int i = 0; i < 30; i++) begin
            cur_reg[i]   <= `DHS_RST_VAL;
            saved_reg[i] <= `DHS_RST_VAL;
         end
      end else begin
         if (state_reg == DHS_SAVE && upd_reg[idx_reg] &&
             (save_only_reg || PREFAIL_MAP[idx_reg])) begin
            saved_reg[idx_reg] <= cur_reg[idx_reg];
            upd_reg[idx_reg]   <= 1'b0;
         end
         if (attr_fire && wd[4:0] < `DHS_N_ATTR) begin
            cur_reg[wd[4:0]] <= wd[15:8];
            upd_reg[wd[4:0]] <= 1'b1;
         end
      end
   end

   // Sector stream pointer and running sum
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         strm_act_reg <= 1'b0;
         strm_thr_reg <= 1'b0;
         strm_ptr_reg <= 9'h000;
         strm_sum_reg <= 8'h00;
      end else if (cmd_fire &&
                   (wd[7:0] == `DHS_SUB_RDVAL || wd[7:0] == `DHS_SUB_RDTHR)) begin
         strm_act_reg <= 1'b1;
         strm_thr_reg <= (wd[7:0] == `DHS_SUB_RDTHR);
         strm_ptr_reg <= 9'h000;
         strm_sum_reg <= 8'h00;
      end else if (data_rd) begin
         strm_sum_reg <= strm_sum_reg + sbyte;
         strm_ptr_reg <= strm_ptr_reg + 9'h001;
         if (strm_ptr_reg == `DHS_O_CSUM) begin
            strm_act_reg <= 1'b0;
         end
      end
   end

   // Byte at the stream pointer; fields are laid out low byte first
   always_comb begin
      rel   = strm_ptr_reg - `DHS_O_ENT;
      ent_i = 5'(rel / `DHS_ENT_BYTES);
      ent_b = 4'(rel % `DHS_ENT_BYTES);
      ent   = entry(ent_i);
      sbyte = 8'h00;
      if (strm_ptr_reg == `DHS_O_CSUM) begin
         sbyte = 8'(8'h00 - strm_sum_reg);
      end else if (strm_ptr_reg < `DHS_O_ENT) begin
         sbyte = strm_ptr_reg[0] ? `DHS_REV_HI : `DHS_REV_LO;
      end else if (strm_ptr_reg < `DHS_O_COLL) begin
         if (ent.id != 8'h00) begin
            case (ent_b)
               4'd0: sbyte = ent.id;
               4'd1: sbyte = strm_thr_reg ? ent.thr : ent.flags[7:0];
               4'd2: sbyte = strm_thr_reg ? 8'h00 : ent.flags[15:8];
               4'd3: sbyte = strm_thr_reg ? 8'h00 : clamp(cur_reg[ent_i]);
               default: sbyte = 8'h00;
            endcase
         end
      end else if (!strm_thr_reg) begin
         case (strm_ptr_reg)
            `DHS_O_COLL:          sbyte = {auto_en_reg, coll_code_reg};
            `DHS_O_ST:            sbyte = st_reg;
            `DHS_O_TTIME:         sbyte = COLL_TIME_S[7:0];
            `DHS_O_TTIME + 9'h001: sbyte = COLL_TIME_S[15:8];
            `DHS_O_OFFCAP:        sbyte = `DHS_OFFCAP;
            `DHS_O_CAP:           sbyte = `DHS_CAP;
            `DHS_O_ELOG:          sbyte = `DHS_ELOG;
            `DHS_O_SHORT:         sbyte = SHORT_MIN;
            `DHS_O_EXT:           sbyte = EXT_MIN;
            default:              sbyte = 8'h00;
         endcase
      end
   end

endmodule
`default_nettype wire

// ===== rtl/dhs_end.sv
/*
   Intentionally empty companion file; all logic lives in dhs_top.
   Assumes nothing.
*/

// ===== verif/dhs_properties.sv
/*
   Port assertions on the bus handshakes and the collection control.
   Assumes a bind from the bench top file, one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module dhs_properties
   import dhs_pkg::*;
(
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic RST_B,
   // Bus handshakes
   input wire logic S_AXI_AWREADY,
   input wire logic S_AXI_WREADY,
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic S_AXI_ARREADY,
   input wire logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // Collection control
   input wire logic COLLECT_EN,
   input wire logic COLLECT_GO
);
   // One domain, so clock and reset are given once
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_B);
   AST_B_ONCE: assert property (
      S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID) else $error("write answer repeated");
   AST_B_BLOCKS: assert property (
      S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY) else $error("write taken early");
   AST_B_REARM: assert property (
      S_AXI_BVALID && S_AXI_BREADY |=> S_AXI_AWREADY && S_AXI_WREADY)
      else $error("write not rearmed");
   AST_R_ONCE: assert property (
      S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID) else $error("read answer repeated");
   AST_AR_BLOCKS: assert property (
      S_AXI_ARREADY != S_AXI_RVALID) else $error("read ready wrong");
   AST_GO_PULSE: assert property (
      COLLECT_GO |=> !COLLECT_GO) else $error("start pulse too long");
   AST_GO_ENABLES: assert property (
      COLLECT_GO |-> ##[0:1] COLLECT_EN) else $error("start without enable");
   AST_EN_CAUSE: assert property (
      $rose(COLLECT_EN) |-> ##[0:1] COLLECT_GO) else $error("enable without start");
endmodule
`default_nettype wire

// ===== verif/dhs_drive_model.sv
/*
   Drive-side stand-in: raises the save request when the bench kicks it.
   Assumes the block's clock.
*/
`timescale 1ns/1ps
`default_nettype none
module dhs_drive_model (
   // Clock and trigger
   input  wire logic clk,
   input  wire logic kick,
   // Request towards the block
   output logic      save_req
);
   logic [2:0] hold_reg = 3'h0;
   // Held four cycles so the synchroniser cannot miss it
   always_ff @(posedge clk)
      hold_reg <= kick ? 3'h4 : hold_reg - {2'h0, hold_reg != 3'h0};
   assign save_req = hold_reg != 3'h0;
endmodule
`default_nettype wire

// ===== verif/dhs_top_tb.sv
/*
   Self-checking bench of the drive health block.
   Assumes design, drive model and checker compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dhs_params.svh"
module dhs_top_tb;
   import dhs_pkg::*;
   localparam logic [7:0]  TH = 8'h10;
   localparam logic [29:0] PF = 30'h0000_0177;
   localparam logic [7:0]  IDS [17] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h08,
      8'h09, 8'h0A, 8'h0C, 8'hC0, 8'hC1, 8'hC2, 8'hC4, 8'hC5, 8'hC6, 8'hC7};
   localparam logic [7:0]  HV [5] = '{8'h00, 8'h10, 8'h11, 8'h00, 8'hFF};
   localparam logic [7:0]  DBC [6] = '{8'hF8, 8'h5A, 8'h00, 8'hF8, 8'hF8, 8'h01};
   logic        clk, rst_b, awv, awr, wv, wrdy, bv, arv, arr, rv, kick, save, en, en_x, err, go;
   logic [7:0]  awa, ara, c, n, vexp, st;
   logic [6:0]  code;
   logic [31:0] wd, rdata, d;
   logic [3:0]  ws;
   logic [1:0]  bresp, rresp, r;
   int          failures = 0, compares = 0, cycles = 0, seed = 9004, gos = 0, ngo = 0;

   dhs_top #(.THR_PREFAIL(TH)) dut_u (.SYS_CLK(clk), .RST_B(rst_b), .S_AXI_AWADDR(awa),
      .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws),
      .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
      .S_AXI_BREADY(1'b1), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(1'b1),
      .SAVE_REQ(save), .COLLECT_EN(en), .COLLECT_GO(go));
   dhs_drive_model drv_u (.clk(clk), .kick(kick), .save_req(save));

   // System clock, 50 ns period
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic final_report;
      if (failures == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp_v);
      compares++;
      if (seen !== exp_v) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp_v);
      end
   endtask

   // Ready is sampled at the falling edge, so it is settled before the taking edge
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
                     output logic [1:0] resp);
      logic pa, pw, ta, tw, t;
      pa = 1'b1;
      pw = 1'b1;
      awa <= a;
      wd <= v;
      ws <= s;
      awv <= 1'b1;
      wv <= 1'b1;
      while (pa || pw) begin
         @(negedge clk);
         ta = pa && awr;
         tw = pw && wrdy;
         @(posedge clk);
         if (ta) awv <= 1'b0;
         if (tw) wv <= 1'b0;
         pa = pa && !ta;
         pw = pw && !tw;
      end
      do begin
         @(negedge clk);
         t = bv;
         resp = bresp;
         @(posedge clk);
      end while (!t);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
      logic t;
      ara <= a;
      arv <= 1'b1;
      do begin
         @(negedge clk);
         t = arr;
         @(posedge clk);
      end while (!t);
      arv <= 1'b0;
      do begin
         @(negedge clk);
         t = rv;
         v = rdata;
         resp = rresp;
         @(posedge clk);
      end while (!t);
   endtask

   function automatic logic [7:0] clamp(input logic [7:0] v);
      return v < 8'h01 ? 8'h01 : (v > 8'hFD ? 8'hFD : v);
   endfunction

   // Expected sector byte; bit 8 clear where the byte is free
   function automatic logic [8:0] want(input logic thr, input int i);
      int k;
      int o;
      k = (i - 2) / 12;
      o = (i - 2) % 12;
      if (i < 2) return i == 0 ? 9'h110 : 9'h100;
      if (i < 'h16A) begin
         if (k > 16 || o == 2 || (thr && o > 1)) return 9'h100;
         if (o == 0) return {1'b1, IDS[k]};
         if (thr) return {1'b1, PF[k] ? TH : 8'h00};
         if (o == 3) return {1'b1, k == 0 ? clamp(vexp) : (k == 3 ? 8'h01 : 8'h64)};
         return o == 1 ? {2'b10, 5'h00, 1'b1, PF[k]} : 9'h000;
      end
      if (thr) return i < 511 ? 9'h100 : 9'h000;
      case (i)
         'h16A: return {1'b1, en_x, code};
         'h16B: return {1'b1, st};
         'h16F: return 9'h11B;
         'h170: return 9'h103;
         'h171: return 9'h100;
         'h172: return 9'h101;
         default: return 9'h000;
      endcase
   endfunction

   task automatic health(input logic [7:0] v);
      vexp = v;
      wr(`DHS_A_ATTR, {16'h0, v, 8'h00}, 4'hF, r);
      wr(`DHS_A_CMD, {24'h0, `DHS_SUB_HEALTH}, 4'hF, r);
      do rd(`DHS_A_STAT, d, r); while (d[17] === 1'b1);
      check(d[15:0], v <= TH ? 16'h2CF4 : 16'hC24F);
   endtask

   task automatic stream(input logic thr);
      logic [8:0] w;
      logic [7:0] sum;
      sum = 8'h00;
      wr(`DHS_A_CMD, {24'h0, thr ? `DHS_SUB_RDTHR : `DHS_SUB_RDVAL}, 4'hF, r);
      for (int i = 0; i < 512; i++) begin
         rd(`DHS_A_DATA, d, r);
         sum = sum + d[7:0];
         w = want(thr, i);
         check(d[8], i == 511);
         if (w[8]) check(d[7:0], w[7:0]);
      end
      check(sum, 8'h00);
      rd(`DHS_A_DATA, d, r);
      check(r, `DHS_SLVERR);
   endtask

   // Start pulses are one cycle wide, so they are counted as they pass
   always @(posedge clk) begin
      if (go === 1'b1) gos <= gos + 1;
   end

   // Cut a hang short
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         failures++;
         final_report;
      end
   end

   initial begin
      {awv, wv, arv, kick, en_x} = 5'h00;
      {awa, ara, wd, ws, code, st} = 67'h0;
      vexp = 8'h64;
      rst_b = 1'b0;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      rd(`DHS_A_STAT, d, r);
      check(d, 32'h0);
      // Power-path save while collection is off; report left alone
      kick <= 1'b1;
      @(posedge clk);
      kick <= 1'b0;
      repeat (6) @(posedge clk);
      rd(`DHS_A_STAT, d, r);
      check(d[17], 1'b1);
      do rd(`DHS_A_STAT, d, r); while (d[17] === 1'b1);
      check(d[15:0], 16'h0);
      // Advisory entry at zero never trips; pre-failure boundary at threshold
      wr(`DHS_A_ATTR, 32'h0000_0003, 4'hF, r);
      for (int j = 0; j < 5; j++) health(j == 0 ? 8'($random(seed)) : HV[j]);
      // Collection keys; entry 3 drops the count byte by strobe
      for (int j = 0; j < 6; j++) begin
         c = j == 3 ? 8'h00 : DBC[j];
         wr(`DHS_A_CMD, {16'h0, DBC[j], `DHS_SUB_AUTO}, j == 3 ? 4'h1 : 4'hF, r);
         err = c != 8'h00 && c != 8'hF8;
         en_x = c == 8'hF8 ? 1'b1 : (err ? en_x : 1'b0);
         rd(`DHS_A_STAT, d, r);
         if (c == 8'hF8) ngo++;
         check(d[18:16], {err, 1'b0, en_x});
         check(en, en_x);
         check(gos, ngo);
      end
      // Status codes 0 to 7, random self-test bytes; illegal ones are kept out
      for (int j = 0; j < 8; j++) begin
         c = 8'(j);
         n = j == 7 ? 8'hF9 : 8'($random(seed));
         wr(`DHS_A_COLL, {16'h0, n, c}, 4'hF, r);
         if (c inside {0, 2, 4, 5, 6}) code = c[6:0];
         if (n[3:0] <= 4'h9 && (n[7:4] <= 4'h7 || n[7:4] == 4'hF)) st = n;
         rd(`DHS_A_COLL, d, r);
         check(d[15:0], {st, 1'b0, code});
      end
      // Unmapped and read-only places
      rd(8'h40, d, r);
      check(r, `DHS_DECERR);
      wr(`DHS_A_DATA, 32'h0, 4'hF, r);
      check(r, `DHS_SLVERR);
      wr(8'h44, 32'h0, 4'hF, r);
      check(r, `DHS_DECERR);
      stream(1'b0);
      stream(1'b1);
      final_report;
   end
endmodule

bind dhs_top dhs_properties chk_u (.SYS_CLK(SYS_CLK), .RST_B(RST_B),
   .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
   .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID),
   .S_AXI_RREADY(S_AXI_RREADY), .COLLECT_EN(COLLECT_EN), .COLLECT_GO(COLLECT_GO));
`default_nettype wire
